/* sgc_frame_tick.sv */
// sgc_frame_tick: free-running divider that makes the internal 8 kHz frame reference pulse.
// assumes one clock; the pulse is one cycle wide every FRAME_CYCLES cycles.
`timescale 1ns/1ps
`default_nettype none
module sgc_frame_tick #(
  parameter int unsigned FRAME_CYCLES = sgc_pkg::FRAME_CYCLES_DEFAULT
) (
  input  wire logic clock,
  input  wire logic rst_n,
  output var  logic frame_tick_q
);
  import sgc_pkg::*;

  localparam int unsigned CW = (FRAME_CYCLES > 1) ? $clog2(FRAME_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(FRAME_CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          tick;
  } sgc_tick_state_type;

  sgc_tick_state_type st_q;
  sgc_tick_state_type st_d;

  always_comb begin
    st_d = st_q;
    if (st_q.count == LAST) begin
      st_d.count = '0;
      st_d.tick  = 1'b1;
    end else begin
      st_d.count = st_q.count + CW'(1);
      st_d.tick  = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign frame_tick_q = st_q.tick;

  AST_TICK_AT_WRAP: assert property (@(posedge clock) disable iff (!rst_n) // [R04]
    st_q.tick |-> (st_q.count == '0)) else $error("frame pulse away from counter wrap");

endmodule
`default_nettype wire

/* sgc_global_control.sv */
// sgc_global_control: global control registers of the time-slot switch (vc command,
// memory configuration, clock set access, phase alignment, fallback command).
// assumes a byte-wide host register port on the same clock, and a host-type pin from the board.
`timescale 1ns/1ps
`default_nettype none
// Contract
// [R01] bridge enable bit works only with pci host; otherwise reserved and ignored.
// [R02] vc command write launches action, then register self-clears to no-operation.
// [R03] vc command codes: 11 start now, 02 pause now, 01/12 framed.
// [R04] framed start or pause acts on the internal 8 kHz frame pulse.
// [R05] memory mode bit 7 enables subrate switching; clear at reset.
// [R06] low seven bits pick 4k single, 2k double, or 2k single+1k double.
// [R07] 22 gives 2k single+256 vc; 12 gives 1k double+256 vc.
// [R08] single buffer minimum delay only; double allows constant delay; capacities per config.
// [R09] packet-only disables standard switching, 512 vc; mixed configs give 256 vc.
// [R10] microprocessor host may only pick the three standard configurations.
// [R11] two clock sets x and y; exactly one active, set by fallback.
// [R12] access selector zero reaches inactive set; value 01 reaches active set.
// [R13] alignment selector: 0 off, 01 snap, 02 slide.
// [R14] alignment acts between internal frame and one chosen incoming reference.
// [R15] fallback command write launches command, then register self-clears.
// [R16] after reset y active, x inactive, accesses go to x.
// [R17] clocks-go makes x active, now or at next frame pulse.
// [R18] fallback-clear flips active assignment after fallback event, now or framed.
// [R19] fallback-force creates fallback event and flips assignment, now or framed.
// [R20] copy command copies active set into inactive set at once only.
// [R21] fallback codes 01 go, 02 clear, 04 force, plus bit 4 framed, 20 copy.
// [R22] memory config 04 selects packet-only with 512 virtual channels.
// [R23] undefined command values do nothing.
module sgc_global_control #(
  parameter int unsigned FRAME_CYCLES = sgc_pkg::FRAME_CYCLES_DEFAULT
) (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       pci_mode_sel,
  input  wire logic                       reg_wr_en,
  input  wire logic                       reg_rd_en,
  input  wire logic [19:0]                reg_addr,
  input  wire logic [7:0]                 reg_wr_data,
  output var  logic [7:0]                 reg_rd_data,
  output var  logic                       reg_rd_valid,
  output var  logic                       vc_switching_enable,
  output var  logic                       subrate_switch_enable,
  output var  logic [6:0]                 memory_config_select,
  output var  logic                       std_switching_enable,
  output var  logic                       constant_delay_capable,
  output var  logic [12:0]                single_buffer_connections,
  output var  logic [12:0]                double_buffer_connections,
  output var  logic [9:0]                 vc_channel_limit,
  output var  logic                       memory_config_invalid,
  output var  logic                       bridge_port_output_enable,
  output var  sgc_pkg::sgc_clock_set_type active_clock_set,
  output var  sgc_pkg::sgc_clock_set_type clock_access_set,
  output var  logic                       alignment_snap,
  output var  logic                       alignment_slide,
  output var  logic                       fallback_pending_event,
  output var  logic                       copy_active_to_inactive,
  output var  logic                       frame_tick
);
  import sgc_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic              pci_sync1;
    logic              pci_sync2;
    logic              bridge_bit;
    logic [7:0]        vc_cmd;
    logic [7:0]        fb_cmd;
    logic [7:0]        mem_cfg;
    logic [7:0]        access_sel;
    logic [7:0]        align_sel;
    sgc_op_type        vc_pend;
    sgc_op_type        fb_pend;
    logic              vc_enable;
    sgc_clock_set_type active_set;
    logic              fallback_event;
    logic              copy_pulse;
    logic [7:0]        rd_data;
    logic              rd_valid;
    logic              bridge_oe;
    sgc_clock_set_type access_set;
    logic              snap;
    logic              slide;
    sgc_mem_cfg_type   cfg;
    logic              cfg_invalid;
  } sgc_state_type;

  sgc_state_type st_q;
  sgc_state_type st_d;
  sgc_cmd_type   vc_dec;
  sgc_cmd_type   fb_dec;

  // one action on the switching state or the clock set assignment
  function automatic sgc_state_type apply_op(input sgc_op_type op, input sgc_state_type s);
    sgc_state_type r;
    r = s;
    case (op)
      OP_VC_START: r.vc_enable = 1'b1;
      OP_VC_PAUSE: r.vc_enable = 1'b0;
      OP_GO:       r.active_set = SET_X; // [R17]
      OP_CLEAR: begin
        // a clear with no outstanding fallback leaves the assignment alone
        if (s.fallback_event) begin // [R18]
          r.active_set     = sgc_clock_set_type'(~s.active_set);
          r.fallback_event = 1'b0;
        end
      end
      OP_FORCE: begin
        r.active_set     = sgc_clock_set_type'(~s.active_set); // [R19]
        r.fallback_event = 1'b1;
      end
      default: r = s; // [R23]
    endcase
    return r;
  endfunction

  // ****************************************************************
  // frame reference
  // ****************************************************************
  sgc_frame_tick #(
    .FRAME_CYCLES (FRAME_CYCLES)
  ) u_frame_tick (
    .clock        (clock),
    .rst_n        (rst_n),
    .frame_tick_q (frame_tick)
  );

  assign vc_dec = decode_command(1'b0, st_q.vc_cmd); // [R03]
  assign fb_dec = decode_command(1'b1, st_q.fb_cmd); // [R21]

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_d            = st_q;
    st_d.pci_sync1  = pci_mode_sel;
    st_d.pci_sync2  = st_q.pci_sync1;
    st_d.vc_cmd     = CMD_NOP; // [R02]
    st_d.fb_cmd     = CMD_NOP; // [R15]
    st_d.copy_pulse = 1'b0;
    st_d.rd_valid   = reg_rd_en;
    st_d.rd_data    = 8'h00;

    if (reg_wr_en) begin
      case (reg_addr)
        ADDR_MASTER_ENABLE: begin
          // the bit is reserved behind a microprocessor host, so the write is dropped
          if (st_q.pci_sync2) begin // [R01]
            st_d.bridge_bit = reg_wr_data[BRIDGE_ENABLE_BIT];
          end
        end
        ADDR_VC_COMMAND:   st_d.vc_cmd     = reg_wr_data; // [R02]
        ADDR_MEM_CONFIG:   st_d.mem_cfg    = reg_wr_data;
        ADDR_CLOCK_ACCESS: st_d.access_sel = reg_wr_data;
        ADDR_ALIGN:        st_d.align_sel  = reg_wr_data;
        ADDR_FALLBACK:     st_d.fb_cmd     = reg_wr_data; // [R15]
        default: ;
      endcase
    end

    // framed commands fire on the frame pulse; an immediate command in the same cycle wins
    if (frame_tick) begin // [R04]
      st_d         = apply_op(st_q.vc_pend, st_d);
      st_d         = apply_op(st_q.fb_pend, st_d);
      st_d.vc_pend = OP_NONE;
      st_d.fb_pend = OP_NONE;
    end

    if (vc_dec.op != OP_NONE) begin // [R23]
      if (vc_dec.framed) begin
        st_d.vc_pend = vc_dec.op; // [R04]
      end else begin
        st_d         = apply_op(vc_dec.op, st_d); // [R03]
        st_d.vc_pend = OP_NONE;
      end
    end

    if (fb_dec.op == OP_COPY) begin
      st_d.copy_pulse = 1'b1; // [R20]
    end else if (fb_dec.op != OP_NONE) begin
      if (fb_dec.framed) begin
        st_d.fb_pend = fb_dec.op; // [R17]
      end else begin
        st_d         = apply_op(fb_dec.op, st_d); // [R11]
        st_d.fb_pend = OP_NONE;
      end
    end

    // decoded views are registered from the next state so they line up with their source;
    // the host-type pin is read only from the second synchroniser stage, never the first
    st_d.bridge_oe   = st_d.bridge_bit & st_q.pci_sync2; // [R01]
    st_d.access_set  = (st_d.access_sel == ACCESS_ACTIVE) ? st_d.active_set :
                       sgc_clock_set_type'(~st_d.active_set); // [R12]
    st_d.snap        = (st_d.align_sel == ALIGN_SNAP); // [R13]
    st_d.slide       = (st_d.align_sel == ALIGN_SLIDE); // [R14]
    st_d.cfg         = mem_cfg_decode(st_d.mem_cfg[6:0]); // [R06] [R07] [R08] [R09] [R22]
    st_d.cfg_invalid = !st_d.cfg.known || (st_d.cfg.vc_cfg && !st_q.pci_sync2); // [R10]

    if (reg_rd_en) begin
      case (reg_addr)
        ADDR_MASTER_ENABLE: st_d.rd_data[BRIDGE_ENABLE_BIT] = st_q.bridge_bit & st_q.pci_sync2;
        ADDR_MEM_CONFIG:    st_d.rd_data = st_q.mem_cfg;
        ADDR_CLOCK_ACCESS:  st_d.rd_data = st_q.access_sel;
        ADDR_ALIGN:         st_d.rd_data = st_q.align_sel;
        default:            st_d.rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q            <= '0;
      st_q.mem_cfg    <= MEM_CONFIG_RESET; // [R05]
      st_q.access_sel <= ACCESS_RESET;
      st_q.align_sel  <= ALIGN_RESET;
      st_q.active_set <= SET_Y; // [R16]
      st_q.access_set <= SET_X;
      st_q.cfg        <= mem_cfg_decode(MEM_CONFIG_RESET[6:0]);
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rd_data               = st_q.rd_data;
  assign reg_rd_valid              = st_q.rd_valid;
  assign vc_switching_enable       = st_q.vc_enable;
  assign subrate_switch_enable     = st_q.mem_cfg[SUBRATE_BIT]; // [R05]
  assign memory_config_select      = st_q.mem_cfg[6:0];
  assign std_switching_enable      = st_q.cfg.std_enable;
  assign constant_delay_capable    = st_q.cfg.constant_delay;
  assign single_buffer_connections = st_q.cfg.sb_conn;
  assign double_buffer_connections = st_q.cfg.db_conn;
  assign vc_channel_limit          = st_q.cfg.vc_chan;
  assign memory_config_invalid     = st_q.cfg_invalid;
  assign bridge_port_output_enable = st_q.bridge_oe;
  assign active_clock_set          = st_q.active_set;
  assign clock_access_set          = st_q.access_set;
  assign alignment_snap            = st_q.snap;
  assign alignment_slide           = st_q.slide;
  assign fallback_pending_event    = st_q.fallback_event;
  assign copy_active_to_inactive   = st_q.copy_pulse;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_VC_SELF_CLEAR: assert property ( // [R02]
    reg_wr_en && reg_addr == ADDR_VC_COMMAND ##1 !(reg_wr_en && reg_addr == ADDR_VC_COMMAND)
    |-> st_q.vc_cmd == $past(reg_wr_data) ##1 st_q.vc_cmd == CMD_NOP)
    else $error("vc command did not self-clear");
  AST_VC_START_NOW: assert property ( // [R03]
    st_q.vc_cmd == VC_START_NOW |=> vc_switching_enable && st_q.vc_pend == OP_NONE)
    else $error("immediate start not applied");
  AST_VC_PAUSE_NOW: assert property ( // [R03]
    st_q.vc_cmd == VC_PAUSE_NOW |=> !vc_switching_enable)
    else $error("immediate pause not applied");
  AST_VC_FRAME_HOLD: assert property ( // [R04]
    st_q.vc_pend == OP_VC_START && !vc_switching_enable && !frame_tick && st_q.vc_cmd == CMD_NOP
    |=> !vc_switching_enable) else $error("framed start acted before frame pulse");
  AST_VC_FRAME_FIRE: assert property ( // [R04]
    st_q.vc_pend == OP_VC_START && frame_tick && st_q.vc_cmd == CMD_NOP |=> vc_switching_enable)
    else $error("framed start missed the frame pulse");
  AST_SUBRATE: assert property ( // [R05]
    reg_wr_en && reg_addr == ADDR_MEM_CONFIG
    |=> {subrate_switch_enable, memory_config_select} == $past(reg_wr_data))
    else $error("subrate enable disagrees with mode byte");
  AST_CFG_4K: assert property ( // [R06]
    memory_config_select == CFG_4K_SB |-> single_buffer_connections == CAP_4096 && !constant_delay_capable
    && vc_channel_limit == 10'h000) else $error("4k configuration decoded wrongly");
  AST_CFG_MIXED: assert property ( // [R07]
    memory_config_select == CFG_1K_DB_256VC |-> double_buffer_connections == CAP_1024 && constant_delay_capable
    && vc_channel_limit == VC_256 && std_switching_enable) else $error("1k plus vc configuration decoded wrongly");
  AST_PACKET_ONLY: assert property ( // [R09]
    memory_config_select == CFG_512VC |-> !std_switching_enable && vc_channel_limit == VC_512)
    else $error("packet-only configuration decoded wrongly");
  AST_ACCESS_TARGET: assert property ( // [R12]
    clock_access_set == ((st_q.access_sel == ACCESS_ACTIVE) ? active_clock_set
                         : sgc_clock_set_type'(~active_clock_set))) else $error("access set steering wrong");
  AST_RESET_SETS: assert property ( // [R16]
    !$past(rst_n) |-> active_clock_set == SET_Y && clock_access_set == SET_X && !vc_switching_enable)
    else $error("clock sets wrong after reset");
  AST_GO_NOW: assert property ( // [R17]
    st_q.fb_cmd == FB_GO |=> active_clock_set == SET_X) else $error("go command did not activate set x");
  AST_FORCE_NOW: assert property ( // [R19]
    st_q.fb_cmd == FB_FORCE |=> active_clock_set != $past(active_clock_set) && fallback_pending_event)
    else $error("force did not flip the active set");
  AST_COPY_PULSE: assert property ( // [R20]
    st_q.fb_cmd == FB_COPY |=> copy_active_to_inactive && $stable(active_clock_set))
    else $error("copy did not pulse at once");
  AST_BRIDGE_GATED: assert property ( // [R01]
    !st_q.pci_sync2 |=> !bridge_port_output_enable) else $error("bridge enabled without pci host");
  AST_UNDEF_NOP: assert property ( // [R23]
    fb_dec.op == OP_NONE && st_q.fb_pend == OP_NONE |=> $stable(active_clock_set))
    else $error("undefined fallback code changed the sets");

  // ****************************************************************
  // fallback command, framed pause and alignment checks
  // ****************************************************************
  AST_FB_SELF_CLEAR: assert property ( // [R15]
    st_q.fb_cmd != CMD_NOP && !(reg_wr_en && reg_addr == ADDR_FALLBACK) |=> st_q.fb_cmd == CMD_NOP)
    else $error("fallback command did not self-clear");

  AST_CLEAR_NOW: assert property ( // [R18]
    st_q.fb_cmd == FB_CLEAR && fallback_pending_event && st_q.fb_pend == OP_NONE
    |=> active_clock_set != $past(active_clock_set) && !fallback_pending_event)
    else $error("clear did not swap the sets back");

  // a waiting framed command leaves the sets alone until the pulse
  AST_FB_FRAME_HOLD: assert property ( // [R17]
    st_q.fb_pend != OP_NONE && !frame_tick && st_q.fb_cmd == CMD_NOP |=> $stable(active_clock_set))
    else $error("framed fallback acted before frame pulse");

  // the pulse applies a waiting force once
  AST_FB_FRAME_FIRE: assert property ( // [R19]
    st_q.fb_pend == OP_FORCE && frame_tick && st_q.fb_cmd == CMD_NOP
    |=> active_clock_set != $past(active_clock_set) && fallback_pending_event)
    else $error("framed force missed the frame pulse");

  // pause waits for the pulse too
  AST_VC_PAUSE_FIRE: assert property ( // [R04]
    st_q.vc_pend == OP_VC_PAUSE && frame_tick && st_q.vc_cmd == CMD_NOP |=> !vc_switching_enable)
    else $error("framed pause missed the frame pulse");

  AST_ALIGN_MODE: assert property ( // [R13]
    reg_wr_en && reg_addr == ADDR_ALIGN |=> alignment_snap == ($past(reg_wr_data) == ALIGN_SNAP)
    && alignment_slide == ($past(reg_wr_data) == ALIGN_SLIDE))
    else $error("alignment flags disagree with selector");

  COV_FRAMED_START: cover property (st_q.vc_cmd == VC_START_FRAME ##[1:300] vc_switching_enable);
  COV_FORCE_CLEAR:  cover property (st_q.fb_cmd == FB_FORCE ##[1:20] st_q.fb_cmd == FB_CLEAR);
  COV_COPY:         cover property (copy_active_to_inactive);
  COV_SLIDE:        cover property (alignment_slide);
  COV_FRAMED_FORCE: cover property (st_q.fb_pend == OP_FORCE && frame_tick);

endmodule
`default_nettype wire

/* sgc_pkg.sv */
// sgc_pkg: constants, types and decode helpers for the switch global control registers.
// assumes an 8-bit register port with 20-bit byte addresses and one 125 MHz clock.
package sgc_pkg;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [19:0] ADDR_MASTER_ENABLE = 20'h00103;
  localparam logic [19:0] ADDR_VC_COMMAND    = 20'h00104;
  localparam logic [19:0] ADDR_MEM_CONFIG    = 20'h00105;
  localparam logic [19:0] ADDR_CLOCK_ACCESS  = 20'h00106;
  localparam logic [19:0] ADDR_ALIGN         = 20'h00107;
  localparam logic [19:0] ADDR_FALLBACK      = 20'h00108;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int unsigned BRIDGE_ENABLE_BIT = 6;
  localparam int unsigned SUBRATE_BIT       = 7;
  localparam logic [7:0]  CMD_NOP           = 8'h00;
  localparam logic [7:0]  MEM_CONFIG_RESET  = 8'h40;
  localparam logic [7:0]  ACCESS_RESET      = 8'h00;
  localparam logic [7:0]  ALIGN_RESET       = 8'h00;

  // ****************************************************************
  // command and selector encodings
  // ****************************************************************
  localparam logic [7:0] VC_START_NOW   = 8'h11;
  localparam logic [7:0] VC_PAUSE_NOW   = 8'h02;
  localparam logic [7:0] VC_START_FRAME = 8'h01;
  localparam logic [7:0] VC_PAUSE_FRAME = 8'h12;
  localparam logic [7:0] FB_GO          = 8'h01;
  localparam logic [7:0] FB_CLEAR       = 8'h02;
  localparam logic [7:0] FB_FORCE       = 8'h04;
  localparam logic [7:0] FB_GO_FRAME    = 8'h11;
  localparam logic [7:0] FB_CLEAR_FRAME = 8'h12;
  localparam logic [7:0] FB_FORCE_FRAME = 8'h14;
  localparam logic [7:0] FB_COPY        = 8'h20;
  localparam logic [7:0] ACCESS_ACTIVE  = 8'h01;
  localparam logic [7:0] ALIGN_SNAP     = 8'h01;
  localparam logic [7:0] ALIGN_SLIDE    = 8'h02;

  localparam logic [6:0] CFG_4K_SB       = 7'h40;
  localparam logic [6:0] CFG_2K_DB       = 7'h20;
  localparam logic [6:0] CFG_2K_SB_1K_DB = 7'h30;
  localparam logic [6:0] CFG_2K_SB_256VC = 7'h22;
  localparam logic [6:0] CFG_1K_DB_256VC = 7'h12;
  localparam logic [6:0] CFG_512VC       = 7'h04;

  localparam logic [12:0] CAP_4096 = 13'h1000;
  localparam logic [12:0] CAP_2048 = 13'h0800;
  localparam logic [12:0] CAP_1024 = 13'h0400;
  localparam logic [9:0]  VC_512   = 10'h200;
  localparam logic [9:0]  VC_256   = 10'h100;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned FRAME_PERIOD_NS      = 125000;
  localparam int unsigned CLOCK_PERIOD_NS      = 8;
  localparam int unsigned FRAME_CYCLES_DEFAULT = FRAME_PERIOD_NS / CLOCK_PERIOD_NS;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_NONE     = 3'b000,
    OP_VC_START = 3'b001,
    OP_VC_PAUSE = 3'b010,
    OP_GO       = 3'b011,
    OP_CLEAR    = 3'b100,
    OP_FORCE    = 3'b101,
    OP_COPY     = 3'b110
  } sgc_op_type;

  typedef enum logic {
    SET_X = 1'b0,
    SET_Y = 1'b1
  } sgc_clock_set_type;

  typedef struct packed {
    logic       framed;
    sgc_op_type op;
  } sgc_cmd_type;

  typedef struct packed {
    logic        known;
    logic        vc_cfg;
    logic        std_enable;
    logic        constant_delay;
    logic [12:0] sb_conn;
    logic [12:0] db_conn;
    logic [9:0]  vc_chan;
  } sgc_mem_cfg_type;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic sgc_cmd_type decode_command(input logic is_fallback, input logic [7:0] v);
    sgc_cmd_type c;
    c = '{framed: 1'b0, op: OP_NONE};
    if (!is_fallback) begin
      case (v)
        VC_START_NOW:   c = '{framed: 1'b0, op: OP_VC_START};
        VC_PAUSE_NOW:   c = '{framed: 1'b0, op: OP_VC_PAUSE};
        VC_START_FRAME: c = '{framed: 1'b1, op: OP_VC_START};
        VC_PAUSE_FRAME: c = '{framed: 1'b1, op: OP_VC_PAUSE};
        default:        c = '{framed: 1'b0, op: OP_NONE};
      endcase
    end else begin
      case (v)
        FB_GO:          c = '{framed: 1'b0, op: OP_GO};
        FB_CLEAR:       c = '{framed: 1'b0, op: OP_CLEAR};
        FB_FORCE:       c = '{framed: 1'b0, op: OP_FORCE};
        FB_GO_FRAME:    c = '{framed: 1'b1, op: OP_GO};
        FB_CLEAR_FRAME: c = '{framed: 1'b1, op: OP_CLEAR};
        FB_FORCE_FRAME: c = '{framed: 1'b1, op: OP_FORCE};
        FB_COPY:        c = '{framed: 1'b0, op: OP_COPY};
        default:        c = '{framed: 1'b0, op: OP_NONE};
      endcase
    end
    return c;
  endfunction

  function automatic sgc_mem_cfg_type mem_cfg_decode(input logic [6:0] sel);
    sgc_mem_cfg_type m;
    m = '0;
    case (sel)
      CFG_4K_SB:       m = '{1'b1, 1'b0, 1'b1, 1'b0, CAP_4096, 13'h0000, 10'h000};
      CFG_2K_DB:       m = '{1'b1, 1'b0, 1'b1, 1'b1, 13'h0000, CAP_2048, 10'h000};
      CFG_2K_SB_1K_DB: m = '{1'b1, 1'b0, 1'b1, 1'b1, CAP_2048, CAP_1024, 10'h000};
      CFG_2K_SB_256VC: m = '{1'b1, 1'b1, 1'b1, 1'b0, CAP_2048, 13'h0000, VC_256};
      CFG_1K_DB_256VC: m = '{1'b1, 1'b1, 1'b1, 1'b1, 13'h0000, CAP_1024, VC_256};
      CFG_512VC:       m = '{1'b1, 1'b1, 1'b0, 1'b0, 13'h0000, 13'h0000, VC_512};
      default:         m = '0;
    endcase
    return m;
  endfunction

endpackage

/* sgc_testbench.sv */
// testbench: self-checking bench for the switch global control register block.
// assumes the design registers every output and takes host strobes on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sgc_pkg::*;
  // ****************************************************************
  // hookup, checks and scenarios; inputs move on the falling edge
  // ****************************************************************
  logic              clock = 1'b0, rst_n = 1'b0, pci = 1'b1, we = 1'b0, re = 1'b0;
  logic [19:0]       ad = 20'h00000;
  logic [7:0]        wd = 8'h00, rd;
  logic              rv, vce, sub, std, inv, br, snap, slide, evt, cpy, tick, cdc;
  logic [12:0]       sb, db;
  logic [9:0]        vcl;
  logic [6:0]        mcs;
  sgc_clock_set_type act, acc;
  int                bad_count = 0, n_compared = 0;
  sgc_global_control #(.FRAME_CYCLES(16)) DUT (.clock(clock), .rst_n(rst_n), .pci_mode_sel(pci),
    .reg_wr_en(we), .reg_rd_en(re), .reg_addr(ad), .reg_wr_data(wd), .reg_rd_data(rd), .reg_rd_valid(rv),
    .vc_switching_enable(vce), .subrate_switch_enable(sub), .memory_config_select(mcs), .std_switching_enable(std),
    .constant_delay_capable(cdc), .single_buffer_connections(sb), .double_buffer_connections(db),
    .vc_channel_limit(vcl), .memory_config_invalid(inv), .bridge_port_output_enable(br), .active_clock_set(act),
    .clock_access_set(acc), .alignment_snap(snap), .alignment_slide(slide), .fallback_pending_event(evt),
    .copy_active_to_inactive(cpy), .frame_tick(tick));
  initial forever #4 clock = ~clock;
  task automatic chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // fields settle two falling edges after the strobe is raised
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    {ad, wd, we} = {a, d, 1'b1};
    @(negedge clock);
    we = 1'b0;
    @(negedge clock);
  endtask
  // read data stands for one cycle only, so it is judged right there
  task automatic rdchk(input logic [19:0] a, input logic [7:0] exp);
    {ad, re} = {a, 1'b1};
    @(negedge clock);
    re = 1'b0;
    chk("rd_data", {4'h0, rv, rd}, {5'h01, exp});
    @(negedge clock);
  endtask
  task automatic t_vc;
    wr(ADDR_VC_COMMAND, 8'h11);
    chk("vc_en", vce, 1'b1);
    rdchk(ADDR_VC_COMMAND, 8'h00);
    wr(ADDR_VC_COMMAND, 8'h02);
    chk("vc_en", vce, 1'b0);
    for (int i = 0; i < 40 && tick !== 1'b1; i++) @(negedge clock);
    wr(ADDR_VC_COMMAND, 8'h01);
    repeat (8) @(negedge clock);
    chk("vc_en", vce, 1'b0);
    for (int i = 0; i < 40 && tick !== 1'b1; i++) @(negedge clock);
    @(negedge clock);
    chk("vc_en", vce, 1'b1);
  endtask
  task automatic t_mem;
    logic [6:0]  code [6] = '{7'h40, 7'h20, 7'h30, 7'h22, 7'h12, 7'h04};
    logic [12:0] sbx [6] = '{13'h1000, 13'h0000, 13'h0800, 13'h0800, 13'h0000, 13'h0000};
    logic [12:0] dbx [6] = '{13'h0000, 13'h0800, 13'h0400, 13'h0000, 13'h0400, 13'h0000};
    logic [9:0]  vcx [6] = '{10'h000, 10'h000, 10'h000, 10'h100, 10'h100, 10'h200};
    rdchk(ADDR_MEM_CONFIG, 8'h40);
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_MEM_CONFIG, {i[0], code[i]});
      chk("sub_std", {sub, std}, {i[0], i != 5});
      chk("sb", sb, sbx[i]);
      chk("db", db, dbx[i]);
      chk("vcl", vcl, {3'h0, vcx[i]});
      chk("cfg", {cdc, mcs}, {dbx[i] != 13'h0000, code[i]});
    end
    rdchk(ADDR_MEM_CONFIG, 8'h84);
  endtask
  task automatic t_fb;
    chk("act_acc", {act, acc}, 2'b10);
    wr(ADDR_FALLBACK, 8'h01);
    chk("act_acc", {act, acc}, 2'b01);
    wr(ADDR_FALLBACK, 8'h04);
    chk("act_evt", {act, evt}, 2'b11);
    wr(ADDR_FALLBACK, 8'h02);
    chk("act_evt", {act, evt}, 2'b00);
    wr(ADDR_FALLBACK, 8'h08);
    chk("act_evt", {act, evt}, 2'b00);
    wr(ADDR_FALLBACK, 8'h20);
    chk("copy", cpy, 1'b1);
    wr(ADDR_CLOCK_ACCESS, 8'h01);
    chk("access", acc, SET_X);
    chk("copy", cpy, 1'b0);
    for (int i = 0; i < 40 && tick !== 1'b1; i++) @(negedge clock);
    wr(ADDR_FALLBACK, 8'h14);
    chk("act_evt", {act, evt}, 2'b00);
    for (int i = 0; i < 40 && tick !== 1'b1; i++) @(negedge clock);
    @(negedge clock);
    chk("act_evt_acc", {act, evt, acc}, 3'b111);
  endtask
  task automatic t_host;
    wr(ADDR_ALIGN, 8'h02);
    chk("align", {snap, slide}, 2'b01);
    wr(ADDR_ALIGN, 8'h01);
    chk("align", {snap, slide}, 2'b10);
    rdchk(20'h001FF, 8'h00);
    wr(ADDR_MASTER_ENABLE, 8'h40);
    chk("bridge", br, 1'b1);
    pci = 1'b0;
    repeat (3) @(negedge clock);
    chk("bridge", br, 1'b0);
    wr(ADDR_MEM_CONFIG, 8'h22);
    chk("invalid", inv, 1'b1);
  endtask
  task automatic close_out;
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    t_fb;
    t_vc;
    t_mem;
    t_host;
    close_out;
  end
  // the scenarios need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    bad_count++;
    close_out;
  end
endmodule
`default_nettype wire
